// >>> hdl/ccs_clock_switch.v
// What this block does
// - from the fast rc clock the cpu clock may move to main crystal, sub crystal, slow rc, or stay.
// - main pin mode pair 01b selects crystal oscillation and 11b external input, set before start.
// - sub pin mode pair 01b selects sub crystal oscillation and 11b external input, set first.
// - clearing the main halt bit starts the main path, after choosing the stabilization time.
// - a readable stabilization counter lets software wait before selecting the main crystal.
// - clearing the sub halt bit starts the sub crystal or external sub clock path.
// - setting main source select picks the main crystal clock, confirmed by main source status.
// - slow rc enable starts the slow rc and makes it the subsystem clock, else sub crystal.
// - cpu sub select moves the cpu to the subsystem clock, confirmed by sub active status.
// - after reset the fast rc runs, and becomes the cpu clock source once its mux leg opens on its third falling edge.
// - setting fast rc halt stops the fast rc, only after the cpu has left it.
`timescale 1ns/1ns
`include "ccs_map.vh"
module ccs_clock_switch (
    input wire clk_i,
    input wire reset_n_i,
    input wire main_ext_input_sel_i,
    input wire main_pin_osc_sel_i,
    input wire main_drive_high_i,
    input wire sub_ext_input_sel_i,
    input wire sub_pin_osc_sel_i,
    input wire sub_drive_level_lo_i,
    input wire sub_drive_level_hi_i,
    input wire sub_low_power_sel_i,
    input wire slow_rc_enable_i,
    input wire [2:0] osc_stab_time_sel_i,
    input wire [2:0] fast_rc_freq_div_i,
    input wire [2:0] main_divider_i,
    input wire main_osc_halt_i,
    input wire sub_osc_halt_i,
    input wire fast_rc_halt_i,
    input wire main_source_select_i,
    input wire cpu_sub_select_i,
    input wire fast_rc_clock_i,
    input wire main_crystal_clock_i,
    input wire sub_crystal_clock_i,
    input wire slow_rc_clock_i,
    output reg main_osc_en_o,
    output reg main_ext_en_o,
    output reg main_amp_high_o,
    output reg sub_osc_en_o,
    output reg sub_ext_en_o,
    output reg [1:0] sub_drive_o,
    output reg sub_low_power_o,
    output reg fast_rc_en_o,
    output reg slow_rc_en_o,
    output reg [2:0] fast_rc_div_o,
    output reg [2:0] main_div_o,
    output reg [`CCS_STAB_W-1:0] osc_stab_counter_o,
    output reg [3:0] cpu_src_sel_o,
    output reg main_source_status_o,
    output reg sub_active_status_o
);
    reg main_run_q;
    reg sub_run_q;
    reg [`CCS_STAB_W-1:0] stab_target;
    wire [3:0] want;
    wire [3:0] on;
    wire [3:0] others_off;
    wire main_is_osc;
    wire main_is_ext;
    wire sub_is_osc;
    wire sub_is_ext;
    wire fast_keep;
    wire slow_keep;

    assign main_is_osc = ({main_ext_input_sel_i, main_pin_osc_sel_i} == `CCS_PIN_MODE_OSC);
    assign main_is_ext = ({main_ext_input_sel_i, main_pin_osc_sel_i} == `CCS_PIN_MODE_EXT);
    assign sub_is_osc = ({sub_ext_input_sel_i, sub_pin_osc_sel_i} == `CCS_PIN_MODE_OSC);
    assign sub_is_ext = ({sub_ext_input_sel_i, sub_pin_osc_sel_i} == `CCS_PIN_MODE_EXT);

    always @*
    begin
        case (osc_stab_time_sel_i)
            3'h0: stab_target = `CCS_STAB_CNT0;
            3'h1: stab_target = `CCS_STAB_CNT1;
            3'h2: stab_target = `CCS_STAB_CNT2;
            3'h3: stab_target = `CCS_STAB_CNT3;
            3'h4: stab_target = `CCS_STAB_CNT4;
            3'h5: stab_target = `CCS_STAB_CNT5;
            3'h6: stab_target = `CCS_STAB_CNT6;
            default: stab_target = `CCS_STAB_CNT7;
        endcase
    end

    // source choice: sub select wins, then main select, otherwise fast rc
    assign want[0] = !cpu_sub_select_i && !main_source_select_i;
    assign want[1] = !cpu_sub_select_i && main_source_select_i;
    assign want[2] = cpu_sub_select_i && !slow_rc_enable_i;
    assign want[3] = cpu_sub_select_i && slow_rc_enable_i;
    assign others_off[0] = ~|(on & 4'he);
    assign others_off[1] = ~|(on & 4'hd);
    assign others_off[2] = ~|(on & 4'hb);
    assign others_off[3] = ~|(on & 4'h7);
    // an rc source stays powered while the mux uses it or is moving onto it, else a
    // stopped source never gives the falling edge its gate needs and the switch hangs
    assign fast_keep = on[0] | want[0];
    assign slow_keep = on[3];

    ccs_clk_gate u_gate_fast (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .src_clk_i(fast_rc_clock_i),
        .want_i(want[0]),
        .others_off_i(others_off[0]),
        .on_o(on[0])
    );
    ccs_clk_gate u_gate_main (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .src_clk_i(main_crystal_clock_i),
        .want_i(want[1]),
        .others_off_i(others_off[1]),
        .on_o(on[1])
    );
    ccs_clk_gate u_gate_sub (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .src_clk_i(sub_crystal_clock_i),
        .want_i(want[2]),
        .others_off_i(others_off[2]),
        .on_o(on[2])
    );
    ccs_clk_gate u_gate_slow (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .src_clk_i(slow_rc_clock_i),
        .want_i(want[3]),
        .others_off_i(others_off[3]),
        .on_o(on[3])
    );

    // main and sub oscillator or external input paths
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            main_run_q <= 1'h0;
            sub_run_q <= 1'h0;
            main_osc_en_o <= 1'h0;
            main_ext_en_o <= 1'h0;
            sub_osc_en_o <= 1'h0;
            sub_ext_en_o <= 1'h0;
        end
        else
        begin
            main_run_q <= !main_osc_halt_i && (main_is_osc || main_is_ext);
            sub_run_q <= !sub_osc_halt_i && (sub_is_osc || sub_is_ext);
            main_osc_en_o <= main_run_q && main_is_osc;
            main_ext_en_o <= main_run_q && main_is_ext;
            sub_osc_en_o <= sub_run_q && sub_is_osc;
            sub_ext_en_o <= sub_run_q && sub_is_ext;
        end
    end

    // on-chip rc oscillators
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            fast_rc_en_o <= 1'h1;
            slow_rc_en_o <= 1'h0;
        end
        else
        begin
            fast_rc_en_o <= !fast_rc_halt_i || fast_keep;
            slow_rc_en_o <= slow_rc_enable_i || slow_keep;
        end
    end

    // drive and divider settings passed on to the oscillator and divider logic
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            main_amp_high_o <= 1'h0;
            sub_drive_o <= 2'h0;
            sub_low_power_o <= 1'h0;
            fast_rc_div_o <= `CCS_RST_FAST_DIV;
            main_div_o <= `CCS_RST_MAIN_DIV;
        end
        else
        begin
            main_amp_high_o <= main_drive_high_i;
            sub_drive_o <= {sub_drive_level_hi_i, sub_drive_level_lo_i};
            sub_low_power_o <= sub_low_power_sel_i;
            fast_rc_div_o <= fast_rc_freq_div_i;
            main_div_o <= main_divider_i;
        end
    end

    // stabilization counter runs from start, saturating at the target
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            osc_stab_counter_o <= {`CCS_STAB_W{1'b0}};
        end
        else
        begin
            if (!main_run_q || !main_is_osc)
            begin
                osc_stab_counter_o <= {`CCS_STAB_W{1'b0}};
            end
            else if (osc_stab_counter_o < stab_target)
            begin
                osc_stab_counter_o <= osc_stab_counter_o + 1'b1;
            end
        end
    end

    // mux state and the status bits seen by software
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cpu_src_sel_o <= 4'h1;
            main_source_status_o <= 1'h0;
            sub_active_status_o <= 1'h0;
        end
        else
        begin
            cpu_src_sel_o <= on;
            main_source_status_o <= on[1];
            sub_active_status_o <= on[2] | on[3];
        end
    end
endmodule

// >>> hdl/ccs_map.vh
`ifndef CCS_MAP_VH
`define CCS_MAP_VH
// pin mode pair encodings {ext_input_sel, pin_osc_sel}
`define CCS_PIN_MODE_OSC 2'h1
`define CCS_PIN_MODE_EXT 2'h3
// stabilization counter width and per-select target counts
`define CCS_STAB_W 18
`define CCS_STAB_CNT0 18'h00100
`define CCS_STAB_CNT1 18'h00200
`define CCS_STAB_CNT2 18'h00400
`define CCS_STAB_CNT3 18'h00800
`define CCS_STAB_CNT4 18'h02000
`define CCS_STAB_CNT5 18'h08000
`define CCS_STAB_CNT6 18'h10000
`define CCS_STAB_CNT7 18'h20000
// reset values
`define CCS_RST_HALT 1'h1
`define CCS_RST_FAST_HALT 1'h0
`define CCS_RST_STAB_SEL 3'h7
`define CCS_RST_FAST_DIV 3'h0
`define CCS_RST_MAIN_DIV 3'h0
// glitch-free mux: idle edges of a source before it is taken; release waits for none
`define CCS_SYNC_EDGES 2'h2
`endif

// >>> hdl/ccs_clk_gate.v
`timescale 1ns/1ns
// one leg of the glitch-free multiplexer, clocked by clk_i and stepped by falling edges of the sampled source
// clock level; the leg opens only after the other legs report closed
module ccs_clk_gate (
    input wire clk_i,
    input wire reset_n_i,
    input wire src_clk_i,
    input wire want_i,
    input wire others_off_i,
    output reg on_o
);
    reg [1:0] sync_q;
    reg src_d1_q;
    reg [1:0] edges_q;
    wire fall;
    assign fall = src_d1_q & ~sync_q[1];
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sync_q <= 2'h0;
            src_d1_q <= 1'h0;
            edges_q <= 2'h0;
            on_o <= 1'h0;
        end
        else
        begin
            sync_q <= {sync_q[0], src_clk_i};
            src_d1_q <= sync_q[1];
            // switch only on a falling edge of this source
            if (fall)
            begin
                if (want_i && others_off_i && !on_o)
                begin
                    if (edges_q == `CCS_SYNC_EDGES)
                    begin
                        on_o <= 1'h1;
                        edges_q <= 2'h0;
                    end
                    else
                    begin
                        edges_q <= edges_q + 2'h1;
                    end
                end
                else if (!want_i && on_o)
                begin
                    on_o <= 1'h0;
                    edges_q <= 2'h0;
                end
                else
                begin
                    edges_q <= 2'h0;
                end
            end
        end
    end
endmodule

// >>> test/ccs_osc_model.sv
`timescale 1ns/1ns
module ccs_osc_model (
    input wire fast_en_i, main_en_i, sub_en_i, slow_en_i,
    output reg fast_clk_o = 0, main_clk_o = 0, sub_clk_o = 0, slow_clk_o = 0
);
    // each source stands low while its oscillator or input path is off
    always #20 fast_clk_o = fast_en_i & ~fast_clk_o;
    always #24 main_clk_o = main_en_i & ~main_clk_o;
    always #32 sub_clk_o = sub_en_i & ~sub_clk_o;
    always #40 slow_clk_o = slow_en_i & ~slow_clk_o;
endmodule

// >>> test/ccs_monitor.sv
`timescale 1ns/1ns
`include "ccs_map.vh"
module ccs_monitor (
    input wire clk_i, reset_n_i, main_ext_input_sel_i, main_pin_osc_sel_i,
    input wire sub_ext_input_sel_i, sub_pin_osc_sel_i, slow_rc_enable_i,
    input wire main_osc_halt_i, sub_osc_halt_i, main_osc_en_o, main_ext_en_o,
    input wire sub_osc_en_o, slow_rc_en_o, fast_rc_en_o, main_source_status_o,
    input wire sub_active_status_o, cpu_sub_select_i, main_source_select_i,
    input wire [2:0] osc_stab_time_sel_i, main_divider_i, main_div_o,
    input wire [`CCS_STAB_W-1:0] osc_stab_counter_o,
    input wire [3:0] cpu_src_sel_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    main_osc_on_a: assert property ((!main_osc_halt_i && {main_ext_input_sel_i,
        main_pin_osc_sel_i} == `CCS_PIN_MODE_OSC)[*3] |-> main_osc_en_o && !main_ext_en_o)
        else $error("main crystal path not enabled");
    main_ext_on_a: assert property ((!main_osc_halt_i && {main_ext_input_sel_i,
        main_pin_osc_sel_i} == `CCS_PIN_MODE_EXT)[*3] |-> main_ext_en_o && !main_osc_en_o)
        else $error("main external path not enabled");
    sub_osc_on_a: assert property ((!sub_osc_halt_i && {sub_ext_input_sel_i,
        sub_pin_osc_sel_i} == `CCS_PIN_MODE_OSC)[*3] |-> sub_osc_en_o)
        else $error("sub crystal path not enabled");
    main_halt_off_a: assert property (main_osc_halt_i[*3] |-> !main_osc_en_o && !main_ext_en_o)
        else $error("main path runs while halted");
    slow_rc_on_a: assert property (slow_rc_enable_i[*3] |-> slow_rc_en_o)
        else $error("slow rc not started");
    div_copy_a: assert property (1 |=> main_div_o == $past(main_divider_i))
        else $error("main divider not copied");
    main_status_a: assert property ($rose(main_source_status_o) |-> cpu_src_sel_o == 4'h2)
        else $error("main status before mux change");
    sub_status_a: assert property ($rose(sub_active_status_o) |->
        (cpu_src_sel_o[2] || cpu_src_sel_o[3]))
        else $error("sub status before mux change");
    sel_onehot_a: assert property ($onehot0(cpu_src_sel_o))
        else $error("more than one cpu source");
    fast_live_a: assert property (cpu_src_sel_o[0] |-> fast_rc_en_o)
        else $error("fast rc stopped while live");
    fast_wanted_a: assert property ((!cpu_sub_select_i && !main_source_select_i)
        |=> fast_rc_en_o) else $error("fast rc stopped while wanted");
    slow_live_a: assert property (cpu_src_sel_o[3] |-> slow_rc_en_o)
        else $error("slow rc stopped while live");
    stab_sat_a: assert property ((osc_stab_time_sel_i == 3'h0)[*2] |->
        osc_stab_counter_o <= `CCS_STAB_CNT0)
        else $error("stabilization counter overran");
    main_cov_c: cover property ($rose(main_source_status_o));
    sub_cov_c: cover property ($rose(sub_active_status_o));
    ext_cov_c: cover property ($rose(main_ext_en_o));
    sub_xtal_cov_c: cover property ($rose(cpu_src_sel_o[2]));
endmodule
bind ccs_clock_switch ccs_monitor ccs_monitor_i (.*);

// >>> test/tb_top.sv
`timescale 1ns/1ns
`include "ccs_map.vh"
module tb_top;
    reg clk_i = 0, reset_n_i = 0, m_ext = 0, m_osc = 0, amp = 0, s_ext = 0, s_osc = 0;
    reg s_lo = 0, s_hi = 0, lp = 0, slow = 0, m_halt = 1, s_halt = 1, f_halt = 0;
    reg m_sel = 0, c_sub = 0;
    reg [2:0] stab = 3'h0, fdiv = 3'h0, main_divider = 3'h0;
    wire fck, mck, sck, lck, m_oe, m_xe, m_amp, s_oe, s_xe, s_lp, f_en, l_en, m_st, s_st;
    wire [1:0] s_drv;
    wire [2:0] f_dv, m_dv;
    wire [17:0] cnt;
    wire [3:0] sel;
    integer n_fail = 0, tests_run = 0, k;
    ccs_clock_switch ccs_clock_switch_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .main_ext_input_sel_i(m_ext), .main_pin_osc_sel_i(m_osc), .main_drive_high_i(amp),
        .sub_ext_input_sel_i(s_ext), .sub_pin_osc_sel_i(s_osc), .sub_drive_level_lo_i(s_lo),
        .sub_drive_level_hi_i(s_hi), .sub_low_power_sel_i(lp), .slow_rc_enable_i(slow),
        .osc_stab_time_sel_i(stab), .fast_rc_freq_div_i(fdiv), .main_divider_i(main_divider),
        .main_osc_halt_i(m_halt), .sub_osc_halt_i(s_halt), .fast_rc_halt_i(f_halt),
        .main_source_select_i(m_sel), .cpu_sub_select_i(c_sub), .fast_rc_clock_i(fck),
        .main_crystal_clock_i(mck), .sub_crystal_clock_i(sck), .slow_rc_clock_i(lck),
        .main_osc_en_o(m_oe), .main_ext_en_o(m_xe), .main_amp_high_o(m_amp),
        .sub_osc_en_o(s_oe), .sub_ext_en_o(s_xe), .sub_drive_o(s_drv), .sub_low_power_o(s_lp),
        .fast_rc_en_o(f_en), .slow_rc_en_o(l_en), .fast_rc_div_o(f_dv), .main_div_o(m_dv),
        .osc_stab_counter_o(cnt), .cpu_src_sel_o(sel), .main_source_status_o(m_st),
        .sub_active_status_o(s_st));
    ccs_osc_model ccs_osc_model_i (.fast_en_i(f_en), .main_en_i(m_oe | m_xe),
        .sub_en_i(s_oe | s_xe), .slow_en_i(l_en), .fast_clk_o(fck), .main_clk_o(mck),
        .sub_clk_o(sck), .slow_clk_o(lck));
    initial forever #4 clk_i = ~clk_i;
    task chk(input [159:0] name, input [17:0] exp, input [17:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp)
            begin
                n_fail = n_fail + 1;
                $display("mismatch %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk_i);
    endtask
    task t_fast;
        begin
            chk("fast_en", 1, f_en);
            f_halt = 1;
            cyc(4);
            chk("fast_held", 1, f_en);
            f_halt = 0;
            for (k = 0; k < 300 && sel !== 4'h1; k = k + 1) cyc(1);
            chk("sel_boot", 4'h1, sel);
        end
    endtask
    task t_main;
        begin
            m_osc = 1;
            amp = 1;
            m_halt = 0;
            cyc(3);
            chk("main_osc_en", 1, m_oe);
            chk("amp", 1, m_amp);
            for (k = 0; k < 400 && cnt !== `CCS_STAB_CNT0; k = k + 1) cyc(1);
            chk("stab_cnt", `CCS_STAB_CNT0, cnt);
            m_sel = 1;
            for (k = 0; k < 300 && m_st !== 1'b1; k = k + 1) cyc(1);
            chk("main_status", 1, m_st);
            chk("sel_main", 4'h2, sel);
            f_halt = 1;
            cyc(4);
            chk("fast_stopped", 0, f_en);
            m_ext = 1;
            cyc(3);
            chk("main_ext_en", 1, m_xe);
            main_divider = 3'h1;
            cyc(1);
            fdiv = 3'h5;
            chk("main_div", 3'h1, m_dv);
            cyc(1);
            chk("fast_div", 3'h5, f_dv);
        end
    endtask
    task t_sub;
        begin
            s_osc = 1;
            s_hi = 1;
            lp = 1;
            cyc(1);
            s_halt = 0;
            slow = 1;
            cyc(60);
            chk("sub_osc_en", 1, s_oe);
            chk("sub_drive", 2'h2, s_drv);
            chk("sub_lp", 1, s_lp);
            chk("slow_en", 1, l_en);
            c_sub = 1;
            for (k = 0; k < 300 && s_st !== 1'b1; k = k + 1) cyc(1);
            chk("sub_status", 1, s_st);
            chk("sel_slow", 4'h8, sel);
        end
    endtask
    task t_back;
        begin
            slow = 0;
            for (k = 0; k < 300 && sel !== 4'h4; k = k + 1) cyc(1);
            chk("sel_sub", 4'h4, sel);
            chk("sub_on", 1, s_st);
            chk("slow_off", 0, l_en);
            s_ext = 1;
            cyc(3);
            chk("sub_ext_en", 1, s_xe);
            f_halt = 0;
            cyc(3);
            chk("fast_restart", 1, f_en);
            c_sub = 0;
            m_sel = 0;
            for (k = 0; k < 300 && sel !== 4'h1; k = k + 1) cyc(1);
            chk("sel_fast", 4'h1, sel);
            chk("main_off", 0, m_st);
            chk("sub_off", 0, s_st);
            m_halt = 1;
            m_ext = 0;
            m_osc = 0;
            stab = 3'h1;
            cyc(1);
            m_halt = 0;
            cyc(3);
            chk("main_refused", 0, m_oe | m_xe);
            m_halt = 1;
            m_osc = 1;
            cyc(1);
            m_halt = 0;
            for (k = 0; k < 600 && cnt !== `CCS_STAB_CNT1; k = k + 1) cyc(1);
            chk("stab_cnt1", `CCS_STAB_CNT1, cnt);
            cyc(4);
            chk("stab_hold", `CCS_STAB_CNT1, cnt);
        end
    endtask
    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial
    begin
        cyc(10);
        reset_n_i = 1;
        cyc(2);
        t_fast;
        t_main;
        t_sub;
        t_back;
        final_report;
    end
    initial
    begin
        #40000;
        n_fail = n_fail + 1;
        final_report;
    end
endmodule
